// File: hw/mclk_cfg_defines.svh
`ifndef MCLK_CFG_DEFINES_SVH
`define MCLK_CFG_DEFINES_SVH

// Register byte addresses, one aligned 32-bit word each.
`define ADDR_CTRL          8'h00
`define ADDR_PLL_CFG       8'h04
`define ADDR_NOMINAL_COUNT 8'h08
`define ADDR_INT_NOMINAL   8'h0c
`define ADDR_ACCUM_SETTING 8'h10
`define ADDR_REF_FREQ      8'h14
`define ADDR_STATUS        8'h18
`define ADDR_MONITOR_CFG   8'h1c

// Control register field positions.
`define CTRL_XTAL_IN_BIT     0
`define CTRL_XTAL_DRIVE_BIT  1
`define CTRL_OSC_EN_BIT      2
`define CTRL_REF_ONE_BIT     3
`define CTRL_REF_TWO_BIT     4
`define CTRL_MSRC_BIT        5
`define CTRL_PSRC_LSB        6
`define CTRL_SINGLE_BIT      9
`define CTRL_ALERT_EN_BIT    10

// Reset values: master divider off, master clock assumed at 204.8 MHz.
`define CTRL_RESET           32'h0000_0000
`define PLL_CFG_RESET        32'h00a0_5000
`define NOMINAL_COUNT_RESET  32'h0000_0800
`define INT_NOMINAL_RESET    32'h0000_0010
`define ACCUM_SETTING_RESET  32'h0000_0000
`define REF_FREQ_RESET       32'h0000_c800
`define MONITOR_CFG_RESET    32'h0000_0840

// Frequency limits in kHz.
`define PD_MIN_KHZ           32'd9720
`define PD_MAX_KHZ           32'd102400
`define DIFF_MAX_KHZ         32'd750000
`define SINGLE_MAX_KHZ       32'd160000

// Monitor measurement window in ns, and its length in cycles of 20 ns.
`define CLK_PERIOD_NS        32'd20
`define MON_WINDOW_NS        32'd5120
`define MON_WINDOW_CYCLES    (`MON_WINDOW_NS / `CLK_PERIOD_NS)

`endif

// File: hw/mclk_cfg_pkg.sv
package mclk_cfg_pkg;

  // Reference monitor phases, Gray coded along the usual path.
  typedef enum logic [1:0] {
    MON_IDLE    = 2'b00,
    MON_MEASURE = 2'b01,
    MON_JUDGE   = 2'b11
  } monitor_state_t;

  // Sources that the second PLL can take as reference.
  typedef enum logic [2:0] {
    PSRC_OSC_PINS = 3'h0,
    PSRC_CRYSTAL  = 3'h1
  } pll_source_t;

endpackage

// File: hw/master_clock_divider.sv
`timescale 1ns/10ps

// Divides the PLL-side clock by two or three into a one-cycle enable pulse.
module master_clock_divider (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] divide,
  output logic            tick
);

  logic [1:0] count; // Cycles since the last pulse.

  // A zero divide field holds the divider stopped; 1 and 2 both give two.
  wire       running  = (divide != 2'h0);
  wire [1:0] last     = (divide == 2'h3) ? 2'h2 : 2'h1;
  wire       wrap     = running && (count >= last);

  // Count restarts only on a wrap or while stopped; a change of divide field does not restart it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 2'h0;
      tick  <= 1'b0;
    end else begin
      count <= (!running || wrap) ? 2'h0 : count + 2'h1;
      tick  <= wrap;
    end
  end

endmodule // master_clock_divider

// File: hw/ref_activity_monitor.sv
`timescale 1ns/10ps

// Counts reference edges over a fixed window and flags absence or gross error.
module ref_activity_monitor #(
  parameter int WINDOW = 256
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ref_edge,
  input  wire logic [7:0] expected,
  input  wire logic [7:0] tolerance,
  output logic            fault,
  output logic            done
);

  mclk_cfg_pkg::monitor_state_t state;   // Current phase.
  mclk_cfg_pkg::monitor_state_t next_state;
  logic [15:0] timer;                    // Window cycle counter.
  logic [8:0]  edges;                    // Edges seen in this window.

  wire        window_end = (timer == 16'(WINDOW - 1));
  wire [8:0]  exp_wide   = {1'b0, expected};
  wire [8:0]  diff       = (edges > exp_wide) ? edges - exp_wide : exp_wide - edges;
  wire        bad        = (edges == 9'h0) || (diff > {1'b0, tolerance});

  // Phase sequencing is a plain loop: measure, judge, measure again.
  always_comb begin
    case (state)
      mclk_cfg_pkg::MON_IDLE:    next_state = mclk_cfg_pkg::MON_MEASURE;
      mclk_cfg_pkg::MON_MEASURE: next_state = window_end ? mclk_cfg_pkg::MON_JUDGE
                                                         : mclk_cfg_pkg::MON_MEASURE;
      mclk_cfg_pkg::MON_JUDGE:   next_state = mclk_cfg_pkg::MON_MEASURE;
      default:                   next_state = mclk_cfg_pkg::MON_IDLE;
    endcase
  end

  // Edge counter saturates so a runaway reference still reads as off frequency.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= mclk_cfg_pkg::MON_IDLE;
      timer <= 16'h0;
      edges <= 9'h0;
      fault <= 1'b0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      timer <= (state == mclk_cfg_pkg::MON_MEASURE && !window_end) ? timer + 16'h1 : 16'h0;
      done  <= (state == mclk_cfg_pkg::MON_JUDGE);
      if (state == mclk_cfg_pkg::MON_JUDGE) begin
        fault <= bad;
        edges <= 9'h0;
      end else if (ref_edge && edges != 9'h1ff) begin
        edges <= edges + 9'h1;
      end
    end
  end

endmodule // ref_activity_monitor

// File: hw/master_clock_source_config.sv
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`include "mclk_cfg_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Both crystal enables set: both pins enabled.
// - Input only: pin is clock input, drive off.
// - Both enables clear: both crystal pins off.
// - PLL reference from oscillator pins or crystal.
// - Phase detector reference 9.72 to 102.4 MHz.
// - Input divider brings up to 750 MHz in range.
// - Defaults assume 204.8 MHz; software reprograms otherwise.
// - PLL output keeps toggling without its reference.
// - Latch failure on dead or gross reference.
// - Master divider off while divide field zero.
// - Each reference receiver enabled by own bit.
// - Input block: 750 MHz differential, 160 single.
// - Direct PLL paths need at least 9.72 MHz.
// - Master divider divides PLL output by two or three.
// - Source select one: oscillator pins drive master; here only while the PLL source is not the crystal.
module master_clock_source_config #(
  parameter int WINDOW = `MON_WINDOW_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Sampled reference levels.
  input  wire logic        osc_ref_pins,
  input  wire logic        crystal_in_pin,
  // Pad and analog controls.
  output logic             crystal_in_pin_enable,
  output logic             crystal_drive_pin_enable,
  output logic             osc_pin_input_enable,
  output logic             ref_input_one_enable,
  output logic             ref_input_two_enable,
  output logic [2:0]       pll_source_select,
  output logic [5:0]       pll_input_divider,
  output logic [9:0]       pll_feedback_multiplier,
  output logic [3:0]       pll_high_speed_divider,
  output logic [1:0]       master_clock_divider,
  output logic [31:0]      master_nominal_count,
  output logic [31:0]      master_integer_nominal,
  output logic [31:0]      master_accumulator_setting,
  // Master clock enable and failure reporting.
  output logic             master_clock_tick,
  output logic             master_ref_failure_latch,
  output logic             failure_alert
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus front end.

  logic [31:0] ctrl;          // Enables and selects.
  logic [31:0] pll_cfg;       // PLL dividers and multiplier.
  logic [31:0] nominal_count; // Master-clock dependent settings.
  logic [31:0] int_nominal;
  logic [31:0] accum_setting;
  logic [31:0] ref_freq;      // Declared reference frequency in kHz.
  logic [31:0] monitor_cfg;   // Expected edges and tolerance.
  logic        wr_pending;    // A write is in its data phase.
  logic [7:0]  wr_addr;       // Address captured for that write.
  logic        fail_latch;    // Sticky failure flag.
  logic        live_fault;    // Most recent monitor verdict.
  logic        ref_prev;      // Previous reference sample for edges.

  // A transfer starts on a selected NONSEQ or SEQ with the bus ready.
  wire         start   = hsel && hready && htrans[1];
  wire         rd_go   = start && !hwrite;
  wire         wr_go   = start && hwrite;
  wire         wr_ctrl = wr_pending && (wr_addr == `ADDR_CTRL);
  wire         wr_pll  = wr_pending && (wr_addr == `ADDR_PLL_CFG);
  wire         wr_nom  = wr_pending && (wr_addr == `ADDR_NOMINAL_COUNT);
  wire         wr_inom = wr_pending && (wr_addr == `ADDR_INT_NOMINAL);
  wire         wr_acc  = wr_pending && (wr_addr == `ADDR_ACCUM_SETTING);
  wire         wr_ref  = wr_pending && (wr_addr == `ADDR_REF_FREQ);
  wire         wr_mon  = wr_pending && (wr_addr == `ADDR_MONITOR_CFG);
  wire         wr_stat = wr_pending && (wr_addr == `ADDR_STATUS);

  // Only whole words are issued, so hsize is not decoded further.
  wire         size_unused = ^hsize;

  // The slave never stalls and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pending <= wr_go;
      wr_addr    <= wr_go ? haddr : wr_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Reset values leave the crystal pins and receivers off and the divider
  // stopped, and set the nominal fields for a 204.8 MHz master clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl          <= `CTRL_RESET;
      pll_cfg       <= `PLL_CFG_RESET;
      nominal_count <= `NOMINAL_COUNT_RESET;
      int_nominal   <= `INT_NOMINAL_RESET;
      accum_setting <= `ACCUM_SETTING_RESET;
      ref_freq      <= `REF_FREQ_RESET;
      monitor_cfg   <= `MONITOR_CFG_RESET;
    end else begin
      if (wr_ctrl) ctrl          <= hwdata & 32'h0000_07ff;
      if (wr_pll)  pll_cfg       <= hwdata & 32'h0cf3_ff3f;
      if (wr_nom)  nominal_count <= hwdata;
      if (wr_inom) int_nominal   <= hwdata;
      if (wr_acc)  accum_setting <= hwdata;
      if (wr_ref)  ref_freq      <= hwdata & 32'h00ff_ffff;
      if (wr_mon)  monitor_cfg   <= hwdata & 32'h0000_ffff;
    end
  end

  // Named fields of the control and PLL words.
  wire       xtal_in     = ctrl[`CTRL_XTAL_IN_BIT];
  wire       xtal_drive  = ctrl[`CTRL_XTAL_DRIVE_BIT];
  wire       osc_en      = ctrl[`CTRL_OSC_EN_BIT];
  wire       msrc_pins   = ctrl[`CTRL_MSRC_BIT];
  wire [2:0] psrc        = ctrl[`CTRL_PSRC_LSB +: 3];
  wire       single_end  = ctrl[`CTRL_SINGLE_BIT];
  wire       alert_en    = ctrl[`CTRL_ALERT_EN_BIT];
  wire [5:0] in_div      = pll_cfg[5:0];
  wire [1:0] mdiv        = pll_cfg[27:26];

  //////////////////////////////////////////////////////////////////////////////
  // Pad enables and analog controls.

  // Drive pin only runs with the input pin; the drive bit alone is ignored.
  wire       next_drive  = xtal_in && xtal_drive;

  // Every control output comes from a flop; fields pass through unchanged except the drive pin enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crystal_in_pin_enable      <= 1'b0;
      crystal_drive_pin_enable   <= 1'b0;
      osc_pin_input_enable       <= 1'b0;
      ref_input_one_enable       <= 1'b0;
      ref_input_two_enable       <= 1'b0;
      pll_source_select          <= 3'h0;
      pll_input_divider          <= 6'h00;
      pll_feedback_multiplier    <= 10'h000;
      pll_high_speed_divider     <= 4'h0;
      master_clock_divider       <= 2'h0;
      master_nominal_count       <= 32'h0;
      master_integer_nominal     <= 32'h0;
      master_accumulator_setting <= 32'h0;
    end else begin
      crystal_in_pin_enable      <= xtal_in;
      crystal_drive_pin_enable   <= next_drive;
      osc_pin_input_enable       <= osc_en;
      ref_input_one_enable       <= ctrl[`CTRL_REF_ONE_BIT];
      ref_input_two_enable       <= ctrl[`CTRL_REF_TWO_BIT];
      pll_source_select          <= psrc;
      pll_input_divider          <= in_div;
      pll_feedback_multiplier    <= pll_cfg[17:8];
      pll_high_speed_divider     <= pll_cfg[23:20];
      master_clock_divider       <= mdiv;
      master_nominal_count       <= nominal_count;
      master_integer_nominal     <= int_nominal;
      master_accumulator_setting <= accum_setting;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frequency range checks against the declared reference frequency.

  // Divider value n divides by n+1; products stay well inside 32 bits.
  wire [31:0] div_plus   = {26'h0, in_div} + 32'h1;
  wire [31:0] pd_low     = `PD_MIN_KHZ * div_plus;
  wire [31:0] pd_high    = `PD_MAX_KHZ * div_plus;
  wire        pd_bad     = (ref_freq < pd_low) || (ref_freq > pd_high);
  wire [31:0] path_max   = single_end ? `SINGLE_MAX_KHZ : `DIFF_MAX_KHZ;
  wire        in_bad     = (ref_freq > path_max)
                         || (ref_freq < `PD_MIN_KHZ);

  //////////////////////////////////////////////////////////////////////////////
  // Reference selection and failure monitor.

  // The oscillator pins only count as a reference once software enabled them;
  // an unused crystal input counts as silent.
  wire osc_ref  = osc_ref_pins && osc_en;
  wire xtal_ref = crystal_in_pin && xtal_in;
  wire pll_ref  = (psrc == mclk_cfg_pkg::PSRC_CRYSTAL) ? xtal_ref : osc_ref;
  wire ref_edge = pll_ref && !ref_prev;

  // Reference levels arrive synchronous to hclk, so one flop finds edges.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= pll_ref;
    end
  end

  wire mon_fault; // Verdict of the latest window.
  wire mon_done;  // One-cycle pulse when a verdict lands.

  // hclk stands for the self-oscillating PLL output, so the monitor keeps
  // judging while the reference is dead.
  ref_activity_monitor #(
    .WINDOW    (WINDOW)
  ) u_monitor (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ref_edge  (ref_edge),
    .expected  (monitor_cfg[7:0]),
    .tolerance (monitor_cfg[15:8]),
    .fault     (mon_fault),
    .done      (mon_done)
  );

  // Sticky flag: a new failure wins over a write-one clear in the same cycle.
  wire clear_fail = wr_stat && hwdata[0];
  wire set_fail   = mon_done && mon_fault;
  wire next_fail  = set_fail || (fail_latch && !clear_fail);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_latch               <= 1'b0;
      live_fault               <= 1'b0;
      master_ref_failure_latch <= 1'b0;
      failure_alert            <= 1'b0;
    end else begin
      fail_latch               <= next_fail;
      live_fault               <= mon_done ? mon_fault : live_fault;
      master_ref_failure_latch <= next_fail;
      failure_alert            <= next_fail && alert_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master clock generation.

  wire div_tick; // Divided PLL output as an enable pulse.

  // The divider stays idle while its field is zero.
  master_clock_divider u_divider (
    .hclk    (hclk),
    .hresetn (hresetn),
    .divide  (mdiv),
    .tick    (div_tick)
  );

  // Source select one hands the oscillator pin edges straight through unless psrc picks the crystal, as ref_prev follows pll_ref.
  wire next_tick = msrc_pins ? (osc_ref && !ref_prev) : div_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_clock_tick <= 1'b0;
    end else begin
      master_clock_tick <= next_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.

  wire [31:0] status_word = {27'h0, (mdiv != 2'h0) || msrc_pins, in_bad, pd_bad,
                             live_fault, fail_latch};

  // Read mux on the address phase; unmapped addresses read zero.
  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0;
    case (haddr)
      `ADDR_CTRL:          rd_value = ctrl;
      `ADDR_PLL_CFG:       rd_value = pll_cfg;
      `ADDR_NOMINAL_COUNT: rd_value = nominal_count;
      `ADDR_INT_NOMINAL:   rd_value = int_nominal;
      `ADDR_ACCUM_SETTING: rd_value = accum_setting;
      `ADDR_REF_FREQ:      rd_value = ref_freq;
      `ADDR_STATUS:        rd_value = status_word;
      `ADDR_MONITOR_CFG:   rd_value = monitor_cfg;
      default:             rd_value = 32'h0;
    endcase
  end

  // Data is captured at the address phase and stands through the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_go) begin
      hrdata <= rd_value ^ {31'h0, size_unused & 1'b0};
    end
  end

endmodule // master_clock_source_config

// File: verif/mclk_cfg_monitor.sv
`timescale 1ns/10ps
`include "mclk_cfg_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Checker for pad controls, master clock ticks and the failure latch.
module mclk_cfg_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        crystal_in_pin_enable,
  input wire logic        crystal_drive_pin_enable,
  input wire logic        osc_pin_input_enable,
  input wire logic        ref_input_one_enable,
  input wire logic        ref_input_two_enable,
  input wire logic [2:0]  pll_source_select,
  input wire logic [5:0]  pll_input_divider,
  input wire logic [1:0]  master_clock_divider,
  input wire logic        master_clock_tick,
  input wire logic        master_ref_failure_latch,
  input wire logic        failure_alert
);
  // Write address phases taken by the slave, per register.
  wire        take    = hsel && hready && htrans[1] && hwrite;
  wire        wr_ctrl = take && haddr == `ADDR_CTRL;
  wire        wr_pll  = take && haddr == `ADDR_PLL_CFG;
  wire        wr_stat = take && haddr == `ADDR_STATUS;
  // Divider settings where ticks come from the divider alone.
  wire        sel0    = !osc_pin_input_enable && master_clock_divider == 2'd0;
  wire        sel2    = !osc_pin_input_enable && master_clock_divider inside {2'd1, 2'd2};
  wire        sel3    = !osc_pin_input_enable && master_clock_divider == 2'd3;
  logic [31:0] wd1;  // Write data one edge old.
  logic [31:0] wd2;  // Write data two edges old.

  // Write data delayed to line up with the pad outputs.
  always_ff @(posedge hclk) begin
    wd1 <= hwdata;
    wd2 <= wd1;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A write is its address phase and then its data phase.
  sequence ctrl_write_s;
    wr_ctrl ##1 1'b1;
  endsequence
  sequence pll_write_s;
    wr_pll ##1 1'b1;
  endsequence

  xtal_pins_a: assert property (
    ctrl_write_s |-> ##2 crystal_in_pin_enable == wd2[0]
      && crystal_drive_pin_enable == (wd2[0] && wd2[1]))
    else $error("crystal enables wrong");
  ref_enables_a: assert property (
    ctrl_write_s |-> ##2
      {ref_input_two_enable, ref_input_one_enable, osc_pin_input_enable} == wd2[4:2])
    else $error("input enables wrong");
  pll_source_a: assert property (ctrl_write_s |-> ##2 pll_source_select == wd2[8:6])
    else $error("pll source wrong");
  divider_field_a: assert property (
    pll_write_s |-> ##2 master_clock_divider == wd2[27:26] && pll_input_divider == wd2[5:0])
    else $error("divider fields wrong");
  drive_needs_in_a: assert property (crystal_drive_pin_enable |-> crystal_in_pin_enable)
    else $error("drive pin enabled without input pin");
  div_off_a: assert property (sel0 [*3] |-> !master_clock_tick)
    else $error("tick while master divider is off");
  div_three_a: assert property (
    sel3 [*8] ##0 master_clock_tick |-> !$past(master_clock_tick)
      && !$past(master_clock_tick, 2) && $past(master_clock_tick, 3))
    else $error("divide by three spacing wrong");
  div_two_a: assert property (
    sel2 [*8] ##0 master_clock_tick |-> !$past(master_clock_tick)
      && $past(master_clock_tick, 2))
    else $error("divide by two spacing wrong");
  alert_latch_a: assert property (failure_alert |-> master_ref_failure_latch)
    else $error("alert without failure latch");
  latch_hold_a: assert property (
    $fell(master_ref_failure_latch) |-> $past(wr_stat, 2) || $past(wr_stat, 3))
    else $error("failure latch cleared unasked");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not okay");
endmodule // mclk_cfg_checker

bind master_clock_source_config mclk_cfg_checker checker_inst (.*);

// File: verif/ref_osc_model.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Stand-in for the external oscillator and the crystal on the reference pins.
module ref_osc_model #(
  parameter int HALF = 2  // Half period of both references, in bus clock cycles.
) (
  input  wire logic hclk,
  input  wire logic osc_run,
  input  wire logic xtal_run,
  input  wire logic osc_pin_input_enable,
  input  wire logic crystal_in_pin_enable,
  output logic      osc_ref_pins,
  output logic      crystal_in_pin
);
  int phase = 0;  // Shared pace, so both references have aligned edges.

  initial {osc_ref_pins, crystal_in_pin} = 2'b00;

  // A pin whose receiver is off toggles each cycle.
  // A stopped reference holds its level, as a dead oscillator would.
  always @(posedge hclk) begin
    phase <= (phase + 1) % HALF;
    osc_ref_pins <= (!osc_pin_input_enable || (osc_run && phase == 0)) ?
      ~osc_ref_pins : osc_ref_pins;
    crystal_in_pin <= (!crystal_in_pin_enable || (xtal_run && phase == 0)) ?
      ~crystal_in_pin : crystal_in_pin;
  end
endmodule // ref_osc_model

// File: verif/tb_master_clock_source_config.sv
`timescale 1ns/10ps
`include "mclk_cfg_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Drives the clock source block over its bus and checks pads, ticks and failures.
module tb_master_clock_source_config;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans, master_clock_divider;
  logic [2:0]  hsize, pll_source_select;
  logic [31:0] hwdata, hrdata, rd, c;
  logic        osc_ref_pins, crystal_in_pin, osc_run, xtal_run;
  logic        crystal_in_pin_enable, crystal_drive_pin_enable, osc_pin_input_enable;
  logic        ref_input_one_enable, ref_input_two_enable;
  logic        master_clock_tick, master_ref_failure_latch, failure_alert;
  logic [5:0]  pll_input_divider;
  logic [9:0]  pll_feedback_multiplier;
  logic [3:0]  pll_high_speed_divider;
  logic [31:0] master_nominal_count, master_integer_nominal, master_accumulator_setting;
  int          err_total, n_tests, cnt;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  // Clock of 20 ns.
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // A short monitor window keeps the failure tests brief.
  master_clock_source_config #(.WINDOW(16)) dut (.*);

  ref_osc_model partner (.*);

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits for ready; only the watchdog ends a wait that never comes.
  task ahb_wait;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  // One single-word transfer: address phase, then data phase.
  task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    ahb_wait;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ahb_wait;
    rd = hrdata;
  endtask

  // Control outputs lag a write.
  task settle;
    repeat (3) @(negedge hclk);
  endtask

  // Sixty idle cycles, ending off the rising edge.
  task idle;
    repeat (60) @(negedge hclk);
  endtask

  // Counts master clock ticks over n cycles.
  task tick_count(input int n);
    cnt = 0;
    repeat (n) begin
      @(negedge hclk);
      if (master_clock_tick === 1'b1) cnt++;
    end
  endtask

  // Expected pad controls for a control word.
  function logic [31:0] exp_pads(input logic [31:0] w);
    return {25'd0, w[8:6], w[4], w[3], w[2], w[0] & w[1], w[0]};
  endfunction

  // Expected ticks over n cycles, give or take one.
  function logic [31:0] near(input int got, input logic [1:0] d, input int n);
    int e;
    e = (d == 2'd0) ? 0 : ((d == 2'd3) ? n / 3 : n / 2);
    return {31'd0, (got - e <= 1) && (e - got <= 1) && (e != 0 || got == 0)};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog, far beyond the test length.
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    osc_run = 1'b1;
    xtal_run = 1'b1;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h56a8));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    check(master_nominal_count, `NOMINAL_COUNT_RESET);
    check(master_integer_nominal, `INT_NOMINAL_RESET);
    check(master_accumulator_setting, `ACCUM_SETTING_RESET);
    check({22'd0, pll_feedback_multiplier, pll_high_speed_divider}, {22'd80, 4'd10});
    ahb_xfer(1'b0, `ADDR_PLL_CFG, 32'h0);
    check(rd, `PLL_CFG_RESET);
    ahb_xfer(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    $display("defaults test done");
    // All crystal enable pairs, random enables and sources.
    for (int i = 0; i < 12; i++) begin
      c = ($urandom() & 32'h0000_01dc) | (i % 4);
      ahb_xfer(1'b1, `ADDR_CTRL, c);
      settle;
      check({25'd0, pll_source_select, ref_input_two_enable, ref_input_one_enable,
        osc_pin_input_enable, crystal_drive_pin_enable, crystal_in_pin_enable},
        exp_pads(c));
      ahb_xfer(1'b0, `ADDR_CTRL, 32'h0);
      check(rd, c);
    end
    $display("pad enable test done");
    ahb_xfer(1'b1, `ADDR_CTRL, 32'h0);
    for (int d = 0; d < 4; d++) begin
      c = (`PLL_CFG_RESET & 32'hf3ff_ffc0) | (32'(d) << 26) | ($urandom() & 32'h3f);
      ahb_xfer(1'b1, `ADDR_PLL_CFG, c);
      settle;
      check({26'd0, pll_input_divider}, {26'd0, c[5:0]});
      tick_count(60);
      check(near(cnt, 2'(d), 60), 32'd1);
    end
    // Direct oscillator path: one tick per four-cycle period.
    ahb_xfer(1'b1, `ADDR_CTRL, 32'h0000_0024);
    settle;
    tick_count(60);
    check(near(cnt, 2'd1, 30), 32'd1);
    // A declared reference below every lower limit flags both range errors.
    ahb_xfer(1'b1, `ADDR_REF_FREQ, 32'd5000);
    ahb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    check({30'd0, rd[3:2]}, 32'd3);
    $display("divider test done");
    // Four reference edges per window, tolerance one, alert enabled.
    ahb_xfer(1'b1, `ADDR_MONITOR_CFG, 32'h0000_0104);
    ahb_xfer(1'b1, `ADDR_CTRL, 32'h0000_0404);
    idle;
    ahb_xfer(1'b1, `ADDR_STATUS, 32'h1);
    idle;
    check({31'd0, master_ref_failure_latch}, 32'd0);
    @(posedge hclk);
    osc_run <= 1'b0;
    idle;
    check({30'd0, master_ref_failure_latch, failure_alert}, 32'd3);
    ahb_xfer(1'b0, `ADDR_STATUS, 32'h0);
    check({31'd0, rd[0]}, 32'd1);
    osc_run <= 1'b1;
    idle;
    check({31'd0, master_ref_failure_latch}, 32'd1);
    ahb_xfer(1'b1, `ADDR_STATUS, 32'h1);
    repeat (4) @(negedge hclk);
    check({30'd0, master_ref_failure_latch, failure_alert}, 32'd0);
    // Crystal source keeps the monitor content with the oscillator dead.
    @(posedge hclk);
    osc_run <= 1'b0;
    ahb_xfer(1'b1, `ADDR_CTRL, 32'h0000_0041);
    idle;
    ahb_xfer(1'b1, `ADDR_STATUS, 32'h1);
    idle;
    check({31'd0, master_ref_failure_latch}, 32'd0);
    $display("failure test done");
    wrap_up;
  end
endmodule // tb_master_clock_source_config
